// [rtl/amas_regbank.sv]
// Local design decision: the APB register port.
`timescale 1ns/10ps
module amas_regbank (
    input  wire logic                                    ref_clk,
    input  wire logic                                    srst,
    input  wire logic                                    clkEn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [amas_pkg::ADDR_W-1:0]             paddr,
    input  wire logic [31:0]                             pwdata,
    input  wire logic [3:0]                              pstrb,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire amas_pkg::amas_cond_s                    conditions,
    input  wire logic                                    convDone,
    output amas_pkg::amas_src_e [amas_pkg::NUM_CH-1:0]   accumSource,
    output logic                                         irq
);
    localparam int FW = amas_pkg::CAUSE_W - amas_pkg::CNT_FULL_BIT;

    logic [7:0]                    modeReg;
    logic [7:0]                    modeNext;
    logic [amas_pkg::CAUSE_W-1:0]  enableReg;
    logic [amas_pkg::CAUSE_W-1:0]  enableNext;
    logic [amas_pkg::IRQ_W-1:0]    irqStatusReg;
    logic [amas_pkg::IRQ_W-1:0]    irqStatusNext;
    logic [amas_pkg::IRQ_W-1:0]    irqMaskReg;
    logic [amas_pkg::IRQ_W-1:0]    irqMaskNext;
    logic [amas_pkg::CAUSE_W-1:0]  condVec;
    logic [amas_pkg::CAUSE_W-1:0]  causeVec;
    logic [FW-1:0]                 flagBits;
    logic [FW-1:0]                 newSet;
    logic [7:0]                    modeRead;
    logic                          access;
    logic                          wrEn;
    logic                          rdEn;
    logic                          causeRead;
    logic                          mapped;
    logic [31:0]                   wmask;

    // field layout of the cause word
    assign condVec[amas_pkg::OC_LSB +: amas_pkg::NUM_CH] = conditions.overCurrent;   // R9
    assign condVec[amas_pkg::UC_LSB +: amas_pkg::NUM_CH] = conditions.underCurrent;  // R9
    assign condVec[amas_pkg::OV_LSB +: amas_pkg::NUM_CH] = conditions.overVoltage;   // R10
    assign condVec[amas_pkg::UV_LSB +: amas_pkg::NUM_CH] = conditions.underVoltage;  // R10
    assign condVec[amas_pkg::OP_LSB +: amas_pkg::NUM_CH] = conditions.overPower;     // R11
    assign condVec[amas_pkg::ACC_FULL_BIT] = conditions.accumFull;                   // R12
    assign condVec[amas_pkg::CNT_FULL_BIT] = conditions.sampleCountFull;             // R13
    assign condVec[amas_pkg::CNT_FULL_BIT-1:0] = '0;                                 // R14

    // APB: zero wait states, single-cycle access phase
    assign access = psel & penable & clkEn;
    assign wrEn = access & pwrite;
    assign rdEn = access & ~pwrite;
    assign pready = 1'b1;
    assign causeRead = rdEn && (paddr == amas_pkg::CAUSE_ADDR);
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        unique case (paddr)
            amas_pkg::MODE_ADDR,
            amas_pkg::CAUSE_ADDR,
            amas_pkg::ENABLE_OFFSET,
            amas_pkg::IRQ_STATUS_OFFSET,
            amas_pkg::IRQ_MASK_OFFSET: mapped = 1'b1;
            default:                   mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    amas_cause_flags #(
        .WIDTH(FW)
    ) u_flags (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .clkEn      (clkEn),
        .condition  (condVec[amas_pkg::CAUSE_W-1:amas_pkg::CNT_FULL_BIT]),
        .enable     (enableReg[amas_pkg::CAUSE_W-1:amas_pkg::CNT_FULL_BIT]),
        .readStrobe (causeRead),
        .convDone   (convDone),
        .flags      (flagBits),
        .newSet     (newSet),
        .clearArmed ()
    );
    assign causeVec = {flagBits, {amas_pkg::CNT_FULL_BIT{1'b0}}};  // R14

    // reserved code reads as zero, decode per channel
    genvar ch;
    generate
        for (ch = 0; ch < amas_pkg::NUM_CH; ch++) begin : g_ch
            localparam int LSB = (amas_pkg::NUM_CH - 1 - ch) * amas_pkg::MODE_W;  // R4
            logic [1:0] code;
            assign code = modeReg[LSB +: amas_pkg::MODE_W];
            assign modeRead[LSB +: amas_pkg::MODE_W] =
                (code == amas_pkg::MODE_RSVD) ? amas_pkg::MODE_POWER : code;     // R3
            always_comb begin
                unique case (code)
                    amas_pkg::MODE_SENSE: accumSource[ch] = amas_pkg::AMAS_SRC_SENSE;  // R1
                    amas_pkg::MODE_BUS:   accumSource[ch] = amas_pkg::AMAS_SRC_BUS;    // R1
                    default:              accumSource[ch] = amas_pkg::AMAS_SRC_POWER;  // R1
                endcase
            end
        end
    endgenerate

    always_comb begin
        modeNext = modeReg;
        enableNext = enableReg;
        irqMaskNext = irqMaskReg;
        irqStatusNext = irqStatusReg;
        if (wrEn) begin
            unique case (paddr)
                amas_pkg::MODE_ADDR: begin
                    modeNext = (modeReg & ~wmask[7:0]) | (pwdata[7:0] & wmask[7:0]);
                end
                amas_pkg::ENABLE_OFFSET: begin
                    enableNext = ((enableReg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]))
                                 & amas_pkg::CAUSE_IMPL_MASK;
                end
                amas_pkg::IRQ_MASK_OFFSET: begin
                    irqMaskNext = pstrb[0] ? pwdata[amas_pkg::IRQ_W-1:0] : irqMaskReg;
                end
                amas_pkg::IRQ_STATUS_OFFSET: begin
                    if (pstrb[0]) begin
                        irqStatusNext = irqStatusReg & ~pwdata[amas_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // set wins over a simultaneous write-one clear
        if (|newSet) begin
            irqStatusNext[amas_pkg::IRQ_TRIP_BIT] = 1'b1;
        end
        if (convDone) begin
            irqStatusNext[amas_pkg::IRQ_CONV_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            modeReg <= amas_pkg::MODE_RESET;      // R2
            enableReg <= amas_pkg::CAUSE_RESET;   // R8
            irqStatusReg <= amas_pkg::IRQ_RESET;
            irqMaskReg <= amas_pkg::IRQ_RESET;
        end else if (clkEn) begin
            modeReg <= modeNext;
            enableReg <= enableNext;
            irqStatusReg <= irqStatusNext;
            irqMaskReg <= irqMaskNext;
        end
    end

    // read data is a mux of flops, not a register: with zero wait states a registered
    // copy would be one cycle stale, and the flag flops already give one coherent snapshot
    always_comb begin
        unique case (paddr)
            amas_pkg::MODE_ADDR:         prdata = {24'h000000, modeRead};
            amas_pkg::CAUSE_ADDR:        prdata = {8'h00, causeVec};      // R15
            amas_pkg::ENABLE_OFFSET:     prdata = {8'h00, enableReg};
            amas_pkg::IRQ_STATUS_OFFSET: prdata = {30'h00000000, irqStatusReg};
            amas_pkg::IRQ_MASK_OFFSET:   prdata = {30'h00000000, irqMaskReg};
            default:                     prdata = 32'h00000000;
        endcase
    end

    assign irq = |(irqStatusReg & irqMaskReg);
endmodule : amas_regbank

// [rtl/amas_pkg.sv]
// Notes on behaviour
// R1 - per-channel mode code 00 power, 01 sense voltage, 10 bus voltage
// R2 - all mode bits reset to zero, every channel starts in power mode
// R3 - mode code 11 is reserved and reads back as zero
// R4 - channel 1 mode in bits 7:6, ch2 5:4, ch3 3:2, ch4 1:0
// R5 - a read of the cause register arms a clear at next conversion end
// R6 - a flag whose condition still holds at conversion end stays set
// R7 - cause register value updates directly, no refresh needed
// R8 - all threshold alerts disabled after reset until software enables them
// R9 - overcurrent flags in bits 23:20, undercurrent in bits 19:16
// R10 - overvoltage flags in bits 15:12, undervoltage in bits 11:8
// R11 - overpower flags in bits 7:4
// R12 - bit 3 set when any channel accumulator overflows or passes its limit
// R13 - bit 2 set when the sample count overflows or passes its limit
// R14 - bits 1:0 of the cause register always read zero
// R15 - a read returns a coherent snapshot; flags set during the read persist
package amas_pkg;
    localparam int NUM_CH = 4;
    localparam int MODE_W = 2;
    localparam int CAUSE_W = 24;
    localparam int ADDR_W = 12;

    localparam logic [11:0] MODE_OFFSET = 12'h025;
    localparam logic [11:0] CAUSE_OFFSET = 12'h026;
    localparam logic [11:0] ENABLE_OFFSET = 12'h028;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h02c;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h030;
    // printed offsets of the two documented registers are word indices, not byte addresses
    localparam logic [11:0] MODE_ADDR = {MODE_OFFSET[9:0], 2'b00};
    localparam logic [11:0] CAUSE_ADDR = {CAUSE_OFFSET[9:0], 2'b00};

    localparam logic [1:0] MODE_POWER = 2'h0;
    localparam logic [1:0] MODE_SENSE = 2'h1;
    localparam logic [1:0] MODE_BUS = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;

    localparam int OC_LSB = 20;
    localparam int UC_LSB = 16;
    localparam int OV_LSB = 12;
    localparam int UV_LSB = 8;
    localparam int OP_LSB = 4;
    localparam int ACC_FULL_BIT = 3;
    localparam int CNT_FULL_BIT = 2;

    localparam logic [23:0] CAUSE_RESET = 24'h000000;
    localparam logic [23:0] CAUSE_IMPL_MASK = 24'hfffffc;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int IRQ_W = 2;
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;

    typedef enum logic [1:0] {
        AMAS_SRC_POWER,
        AMAS_SRC_SENSE,
        AMAS_SRC_BUS
    } amas_src_e;

    typedef struct packed {
        logic [NUM_CH-1:0] overCurrent;
        logic [NUM_CH-1:0] underCurrent;
        logic [NUM_CH-1:0] overVoltage;
        logic [NUM_CH-1:0] underVoltage;
        logic [NUM_CH-1:0] overPower;
        logic              accumFull;
        logic              sampleCountFull;
    } amas_cond_s;
endpackage : amas_pkg

// [rtl/amas_cause_flags.sv]
`timescale 1ns/10ps
module amas_cause_flags #(
    parameter int WIDTH = 22
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] condition,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic             readStrobe,
    input  wire logic             convDone,
    output logic      [WIDTH-1:0] flags,
    output logic      [WIDTH-1:0] newSet,
    output logic                  clearArmed
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;
    logic             armed_reg;
    logic             armed_next;
    logic [WIDTH-1:0] hit;

    always_comb begin
        hit = condition & enable;                       // R8
        newSet = hit & ~flags_reg;
        armed_next = armed_reg;
        flags_next = flags_reg | hit;                   // R7
        if (convDone && armed_reg) begin
            // R5 R6: clear, but any enabled condition still active keeps its flag
            flags_next = hit;
            armed_next = 1'b0;
        end
        // a read in the same cycle as conversion end arms the next cycle
        if (readStrobe) begin
            armed_next = 1'b1;                          // R5
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_reg <= '0;
            armed_reg <= 1'b0;
        end else if (clkEn) begin
            flags_reg <= flags_next;
            armed_reg <= armed_next;
        end
    end

    assign flags = flags_reg;
    assign clearArmed = armed_reg;
endmodule : amas_cause_flags

// [tb/amas_regbank_chk.sv]
`timescale 1ns/10ps
module amas_regbank_chk (
    input wire logic                      ref_clk,
    input wire logic                      srst,
    input wire logic                      clkEn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [3:0]                pstrb,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire amas_pkg::amas_cond_s      conditions,
    input wire logic                      convDone,
    input wire amas_pkg::amas_src_e [3:0] accumSource,
    input wire logic                      irq
);
    localparam logic [11:0] MA = {amas_pkg::MODE_OFFSET[9:0], 2'b00};
    localparam logic [11:0] CA = {amas_pkg::CAUSE_OFFSET[9:0], 2'b00};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire acc = psel && penable && clkEn;
    wire modeRd = acc && !pwrite && paddr == MA;
    wire causeRd = acc && !pwrite && paddr == CA;
    wire clr = convDone && clkEn;
    // a read with no conversion end at its own edge arms a fresh clear
    sequence armed;
        causeRd && !clr;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    reset_vals_a: assert property ($past(srst) && $past(clkEn) |-> !irq && accumSource == '0)
        else $error("state not cleared by reset");
    mode_rsvd_a: assert property (modeRd |-> prdata[7:6] != 2'h3 && prdata[5:4] != 2'h3
        && prdata[3:2] != 2'h3 && prdata[1:0] != 2'h3) else $error("reserved mode read back");
    mode_src_a: assert property (modeRd |-> prdata[31:8] == '0 && accumSource ==
        {prdata[1:0], prdata[3:2], prdata[5:4], prdata[7:6]}) else $error("mode source mismatch");
    cause_unimpl_a: assert property (causeRd |-> prdata[1:0] == '0 && prdata[31:24] == '0)
        else $error("unimplemented cause bits set");
    flags_kept_a: assert property (armed ##1 !clr ##1 causeRd |->
        ($past(prdata, 2) & ~prdata & 32'h00fffffc) == '0) else $error("flag lost without clear");
    cond_holds_a: assert property (causeRd && prdata[23] ##1 clr && conditions.overCurrent[3]
        ##1 causeRd |-> prdata[23]) else $error("persisting flag cleared");
    flags_clear_a: assert property (armed ##1 clr && conditions == '0 ##1 causeRd |->
        prdata[23:2] == '0) else $error("flags not cleared");
    unmapped_err_a: assert property (acc && paddr == 12'h0fc |-> pslverr && prdata == '0)
        else $error("unmapped access accepted");
endmodule : amas_regbank_chk
bind amas_regbank amas_regbank_chk u_chk (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conditions(conditions), .convDone(convDone), .accumSource(accumSource), .irq(irq));

// [tb/accum_mode_alert_status_bench.sv]
`timescale 1ns/10ps
module accum_mode_alert_status_bench;
    localparam logic [11:0] MA = {amas_pkg::MODE_OFFSET[9:0], 2'b00};
    localparam logic [11:0] CA = {amas_pkg::CAUSE_OFFSET[9:0], 2'b00};
    logic                 ref_clk = 1'b0;
    logic                 srst = 1'b1;
    logic                 clkEn = 1'b1;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = '0;
    logic [31:0]          pwdata = '0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 convDone = 1'b0;
    amas_pkg::amas_cond_s conditions = '0;
    amas_pkg::amas_src_e  [3:0] accumSource;
    logic                 irq;
    logic [31:0]          rd;
    logic                 err;
    int                   error_cnt = 0;
    int                   check_count = 0;
    // mode rows: written value, read-back value, sources {ch4..ch1}
    logic [7:0]           wr [3] = '{8'h1b, 8'he4, 8'h00};
    logic [7:0]           ex [3] = '{8'h18, 8'h24, 8'h00};
    logic [7:0]           sx [3] = '{8'h24, 8'h18, 8'h00};

    always #50 ref_clk = ~ref_clk;

    amas_regbank u_dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conditions(conditions),
        .convDone(convDone), .accumSource(accumSource), .irq(irq));

    // psel is left high so transfers run back to back; the caller drops it at gaps
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic cv);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        convDone <= cv;
        @(posedge ref_clk);
        penable <= 1'b1;
        convDone <= 1'b0;
        // the answer is taken at the rising edge that samples pready high; only the
        // watchdog ends a wait that never gets an answer
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask : apb

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(400 * 100);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        conditions <= '1;
        apb(0, MA, 0, 0);
        cmp(rd, 0);
        cmp({24'h0, accumSource}, 0);
        apb(0, CA, 0, 0);
        cmp(rd, 0);
        for (int i = 0; i < 3; i++) begin
            apb(1, MA, {24'h0, wr[i]}, 0);
            apb(0, MA, 0, 0);
            cmp(rd, {24'h0, ex[i]});
            cmp({24'h0, accumSource}, {24'h0, sx[i]});
        end
        conditions <= 22'h206063;
        apb(1, amas_pkg::ENABLE_OFFSET, 32'h00fffffc, 0);
        apb(0, CA, 0, 0);
        cmp(rd, 32'h0081818c);
        conditions <= 22'h200000;
        apb(0, CA, 0, 0);
        cmp(rd, 32'h0081818c);
        // only the channel 4 overcurrent condition is still active here
        apb(0, CA, 0, 1);
        cmp(rd, 32'h00800000);
        conditions <= '0;
        apb(0, CA, 0, 1);
        cmp(rd, 0);
        cmp({31'h0, irq}, 0);
        apb(1, amas_pkg::IRQ_MASK_OFFSET, 32'h1, 0);
        apb(0, amas_pkg::IRQ_STATUS_OFFSET, 0, 0);
        cmp(rd, 32'h3);
        cmp({31'h0, irq}, 1);
        apb(1, amas_pkg::IRQ_STATUS_OFFSET, 32'h3, 0);
        clkEn <= 1'b0;
        apb(1, MA, 32'h55, 0);
        cmp({31'h0, irq}, 0);
        clkEn <= 1'b1;
        apb(0, MA, 0, 0);
        cmp(rd, 0);
        apb(0, 12'h0fc, 0, 0);
        cmp(rd, 0);
        cmp({31'h0, err}, 1);
        // a reset in mid-run must bring a programmed mode back to power accumulation
        apb(1, MA, 32'h5a, 0);
        apb(0, MA, 0, 0);
        cmp(rd, 32'h5a);
        psel <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        apb(0, MA, 0, 0);
        cmp(rd, 0);
        cmp({24'h0, accumSource}, 0);
        psel <= 1'b0;
        @(posedge ref_clk);
        tally_and_finish();
    end
endmodule : accum_mode_alert_status_bench
